// ===== pkg/gdsm_pkg.sv
// Package of constants and types for the gyro diagnostic status monitor
// Overview of operation
// - Seven monitors each drive a status flag low on an irregular condition.
// - A status-read command returns the eight-bit flag byte.
// - A low flag is stretched to hold low for 1.5 to 2.0 ms.
// - Bit 7 shows converter overflow, low on overflow, recoverable.
// - Bit 6 low on processing arithmetic overflow, except output scaling saturation.
// - Bit 5 low when calibration memory parity fails, not recoverable.
// - Bit 4 low during analog test mode, never substitutes the error code.
// - Bit 3 high only while analog supply is inside its window.
// - Supply outside window makes both rate reads return the error code.
// - Bit 2 low on open or leaking electrode, not recoverable.
// - Bit 1 low when excitation loses lock, recoverable.
// - Bit 0 unused and always reads one.
// - Until excitation lock first rises, rate reads return the error code.
// - After start-up, real rate data is delivered on reads.
// - After start-up, any error flag low latches error code and freezes processing.
// - Latched error lasts until power-down, or recovery for recoverable cases.
// - Recovery command ignored unless all three guard-disable steps came first.
// - No new error is latched while the guard is disabled.
// - Guard-enable command re-arms latching and resumes normal operation.
// - Internal reset is held at least 50 us before calibration memory power-down.
// - Rate data is a 12-bit two's complement word in high and low bytes.
package gdsm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned STRETCH_US      = 1600;    // Inside 1.5..2.0 ms
    localparam int unsigned STRETCH_CYC     = STRETCH_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PDRST_NS        = 50_000;
    localparam int unsigned PDRST_CYC       = (PDRST_NS + 19) / 20;
    localparam int unsigned STRETCH_W       = 17;
    localparam int unsigned PDRST_W         = 12;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_ADC         = 7;
    localparam int unsigned BIT_ARITH       = 6;
    localparam int unsigned BIT_CALIB       = 5;
    localparam int unsigned BIT_ATEST       = 4;
    localparam int unsigned BIT_SUPPLY      = 3;
    localparam int unsigned BIT_ELECT       = 2;
    localparam int unsigned BIT_EXC         = 1;
    localparam logic [7:0]  STATUS_RESET    = 8'hff;
    localparam logic [7:0]  ERR_MASK        = 8'hee;   // Flags that latch an error
    localparam logic [7:0]  NONREC_MASK     = 8'h6c;   // Bits 6,5,3,2
    localparam logic [7:0]  ERR_CODE_HI     = 8'h80;
    localparam logic [7:0]  ERR_CODE_LO     = 8'h80;

    // ------------------------------------------------------------
    // Commands and types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GDSM_CMD_NONE,
        GDSM_CMD_READ_STATUS,
        GDSM_CMD_READ_RATE_HIGH,
        GDSM_CMD_READ_RATE_LOW,
        GDSM_CMD_GUARD_DISABLE,
        GDSM_CMD_RECOVER,
        GDSM_CMD_GUARD_ENABLE
    } gdsm_cmd_t;

    typedef struct packed {
        logic adc_no_overflow;
        logic arith_no_overflow;
        logic calib_parity_good;
        logic analog_test_off;
        logic supply_in_window;
        logic electrode_good;
        logic excitation_locked;
    } gdsm_mon_t;

    typedef struct packed {
        logic       valid;
        gdsm_cmd_t  cmd;
        logic [1:0] step;   // Guard-disable step 1..3
    } gdsm_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } gdsm_rsp_t;
endpackage

// ===== rtl/gdsm_stretch.sv
// Pulse stretcher for one low-active status flag
`timescale 1ns/1ps
`default_nettype none
module gdsm_stretch (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    // Flag
    input  wire logic flag_i,
    output logic      flag_o
);
    typedef struct packed {
        logic [gdsm_pkg::STRETCH_W-1:0] cnt;
        logic                           flag;
    } gdsm_str_t;

    gdsm_str_t s_q, s_d;

    // Reload on every low sample, hold low until the count runs out
    always_comb begin
        s_d = s_q;
        if (!flag_i) begin
            s_d.cnt  = gdsm_pkg::STRETCH_W'(gdsm_pkg::STRETCH_CYC - 1);
            s_d.flag = 1'b0;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end else begin
            s_d.flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{cnt: '0, flag: 1'b1};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign flag_o = s_q.flag;
endmodule
`default_nettype wire

// ===== rtl/gdsm_top.sv
// Diagnostic status monitor: flags, error latch, guard and rate substitution
`timescale 1ns/1ps
`default_nettype none
module gdsm_top (
    // Clock and reset
    input  wire logic                clock_i,
    input  wire logic                nrst_i,
    input  wire logic                ce_i,
    // Monitor inputs
    input  wire gdsm_pkg::gdsm_mon_t mon_i,
    // Calibration memory power-down request
    input  wire logic                pd_req_i,
    // Rate datapath
    input  wire logic [11:0]         rate_i,
    // Host commands and answers
    input  wire gdsm_pkg::gdsm_req_t req_i,
    output gdsm_pkg::gdsm_rsp_t      rsp_o,
    // Status and control outputs
    output logic [7:0]               diagnostic_status_o,
    output logic                     error_latched_o,
    output logic                     proc_freeze_o,
    output logic                     startup_done_o,
    output logic                     guard_enabled_o,
    output logic                     int_rst_o,
    output logic                     pd_ok_o
);
    // ------------------------------------------------------------
    // Stretched monitor flags
    // ------------------------------------------------------------
    logic [7:0] raw;
    logic [7:0] str;

    // Monitor bits in register order; bit 0 has no monitor
    assign raw = {mon_i.adc_no_overflow, mon_i.arith_no_overflow,
                  mon_i.calib_parity_good, mon_i.analog_test_off,
                  mon_i.supply_in_window, mon_i.electrode_good,
                  mon_i.excitation_locked, 1'b1};

    // One stretcher per monitored bit
    genvar g;
    generate
        for (g = 1; g < 8; g++) begin : g_str
            gdsm_stretch u_str (
                .clock_i (clock_i),
                .nrst_i  (nrst_i),
                .ce_i    (ce_i),
                .flag_i  (raw[g]),
                .flag_o  (str[g])
            );
        end
    endgenerate
    assign str[0] = 1'b1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GDSM_G_ARMED,
        GDSM_G_DIS1,
        GDSM_G_DIS2,
        GDSM_G_OPEN
    } gdsm_guard_t;

    typedef struct packed {
        gdsm_guard_t                  guard;
        logic                         armed;
        logic                         started;
        logic                         err;
        logic [7:0]                   status;
        gdsm_pkg::gdsm_rsp_t          rsp;
        logic [11:0]                  rate_hold;
        logic                         freeze;
        logic                         irst;
        logic                         pd_ok;
        logic [gdsm_pkg::PDRST_W-1:0] pd_cnt;
    } gdsm_state_t;

    gdsm_state_t q, d;

    logic subst;
    logic err_now;
    logic [11:0] rate_out;

    // Error code whenever not started, latched, or supply out of window;
    // taken from the status byte so substitution never runs ahead of what the host sees
    assign subst   = !q.started || q.err
                     || !q.status[gdsm_pkg::BIT_SUPPLY];
    // Any error-signalling flag low in the status byte, bit 4 and 0 excluded by mask
    assign err_now = ((~q.status) & gdsm_pkg::ERR_MASK) != 8'h00;
    // Freeze holds the last good sample
    assign rate_out = q.freeze ? q.rate_hold : rate_i;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.status    = str;
        d.rsp.valid = 1'b0;

        // Start-up ends at first excitation lock; the raw level is needed too,
        // since the stretcher leaves reset showing good and would end it at once
        if (raw[gdsm_pkg::BIT_EXC] && str[gdsm_pkg::BIT_EXC]) begin
            d.started = 1'b1;
        end

        // Latch only when armed and after start-up
        if (q.started && q.guard == GDSM_G_ARMED && err_now) begin
            d.err = 1'b1;
        end

        if (!q.freeze) begin
            d.rate_hold = rate_i;
        end

        // Command handling
        if (req_i.valid) begin
            case (req_i.cmd)
                gdsm_pkg::GDSM_CMD_READ_STATUS: begin
                    d.rsp = '{valid: 1'b1, data: str};
                end
                gdsm_pkg::GDSM_CMD_READ_RATE_HIGH: begin
                    d.rsp.valid = 1'b1;
                    d.rsp.data  = subst ? gdsm_pkg::ERR_CODE_HI
                                        : {{4{rate_out[11]}}, rate_out[11:8]};
                end
                gdsm_pkg::GDSM_CMD_READ_RATE_LOW: begin
                    d.rsp.valid = 1'b1;
                    d.rsp.data  = subst ? gdsm_pkg::ERR_CODE_LO : rate_out[7:0];
                end
                gdsm_pkg::GDSM_CMD_GUARD_DISABLE: begin
                    // Steps must come in order 1,2,3; a wrong step re-arms
                    case (q.guard)
                        GDSM_G_ARMED: d.guard = (req_i.step == 2'd1) ? GDSM_G_DIS1 : GDSM_G_ARMED;
                        GDSM_G_DIS1:  d.guard = (req_i.step == 2'd2) ? GDSM_G_DIS2 : GDSM_G_ARMED;
                        GDSM_G_DIS2:  d.guard = (req_i.step == 2'd3) ? GDSM_G_OPEN : GDSM_G_ARMED;
                        default:      d.guard = q.guard;
                    endcase
                end
                gdsm_pkg::GDSM_CMD_RECOVER: begin
                    // Ignored unless the guard is fully open
                    if (q.guard == GDSM_G_OPEN &&
                        (q.status & gdsm_pkg::NONREC_MASK) == gdsm_pkg::NONREC_MASK) begin
                        d.err = 1'b0;
                    end
                end
                gdsm_pkg::GDSM_CMD_GUARD_ENABLE: begin
                    d.guard = GDSM_G_ARMED;
                end
                default: begin
                    d.guard = q.guard;
                end
            endcase
        end

        d.freeze = d.err;
        d.armed  = (d.guard == GDSM_G_ARMED);

        // Reset pulse before calibration memory power-down
        if (pd_req_i) begin
            d.irst = 1'b1;
            if (q.pd_cnt != gdsm_pkg::PDRST_W'(gdsm_pkg::PDRST_CYC)) begin
                d.pd_cnt = q.pd_cnt + 1'b1;
            end
            d.pd_ok = (q.pd_cnt == gdsm_pkg::PDRST_W'(gdsm_pkg::PDRST_CYC));
        end else begin
            d.irst   = 1'b0;
            d.pd_ok  = 1'b0;
            d.pd_cnt = '0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '{guard: GDSM_G_ARMED, armed: 1'b1, started: 1'b0, err: 1'b0,
                   status: gdsm_pkg::STATUS_RESET, rsp: '0, rate_hold: '0,
                   freeze: 1'b0, irst: 1'b0, pd_ok: 1'b0, pd_cnt: '0};
        end else if (ce_i) begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign rsp_o               = q.rsp;
    assign diagnostic_status_o = q.status;
    assign error_latched_o     = q.err;
    assign proc_freeze_o       = q.freeze;
    assign startup_done_o      = q.started;
    assign guard_enabled_o     = q.armed;
    assign int_rst_o           = q.irst;
    assign pd_ok_o             = q.pd_ok;
endmodule
`default_nettype wire

// ===== dv/gdsm_checker.sv
// Assertion checker for the diagnostic status monitor
`timescale 1ns/1ps
`default_nettype none
module gdsm_checker (
    // Clock and reset
    input wire logic                clock_i,
    input wire logic                nrst_i,
    input wire logic                ce_i,
    // Stimulus side
    input wire gdsm_pkg::gdsm_mon_t mon_i,
    input wire logic                pd_req_i,
    input wire gdsm_pkg::gdsm_req_t req_i,
    // Design outputs
    input wire gdsm_pkg::gdsm_rsp_t rsp_o,
    input wire logic [7:0]          diagnostic_status_o,
    input wire logic                error_latched_o,
    input wire logic                proc_freeze_o,
    input wire logic                startup_done_o,
    input wire logic                guard_enabled_o,
    input wire logic                int_rst_o,
    input wire logic                pd_ok_o
);
    // ------------------------------------------------------------
    // Helper terms and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire logic rate = ce_i && req_i.valid && (req_i.cmd == gdsm_pkg::GDSM_CMD_READ_RATE_HIGH
                      || req_i.cmd == gdsm_pkg::GDSM_CMD_READ_RATE_LOW);
    wire logic rd   = rate || (ce_i && req_i.valid && req_i.cmd == gdsm_pkg::GDSM_CMD_READ_STATUS);
    wire logic bad  = (diagnostic_status_o & gdsm_pkg::ERR_MASK) != gdsm_pkg::ERR_MASK;
    wire logic nrec = (diagnostic_status_o & gdsm_pkg::NONREC_MASK) != gdsm_pkg::NONREC_MASK;

    stat_bit0_a:  assert property (diagnostic_status_o[0])
        else $error("unused status bit not one");
    rsp_lat_a:    assert property (rd |=> rsp_o.valid)
        else $error("read answer missing");
    rsp_only_a:   assert property (rsp_o.valid |-> $past(rd))
        else $error("answer without read");
    stat_low_a:   assert property (ce_i && !mon_i.adc_no_overflow
        |-> ##2 !diagnostic_status_o[7])
        else $error("overflow flag not shown");
    ecode_sub_a:  assert property (rate
        && (error_latched_o || !startup_done_o || !diagnostic_status_o[3])
        |=> rsp_o.data == 8'h80)
        else $error("error code not substituted");
    freeze_err_a: assert property (proc_freeze_o == error_latched_o)
        else $error("freeze differs from latch");
    latch_set_a:  assert property (startup_done_o && guard_enabled_o && bad
        |=> error_latched_o)
        else $error("error not latched");
    guard_hold_a: assert property (!guard_enabled_o && !error_latched_o
        |=> !error_latched_o)
        else $error("latched while guard open");
    nrec_keep_a:  assert property (error_latched_o && nrec |=> error_latched_o)
        else $error("latch cleared on lasting error");
    rst_hold_a:   assert property ($rose(pd_ok_o) |-> int_rst_o && $past(int_rst_o))
        else $error("power-down allowed without reset");
    cover property ($rose(error_latched_o));
    cover property ($fell(error_latched_o));
    cover property (!guard_enabled_o);
endmodule
bind gdsm_top gdsm_checker chk (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .mon_i(mon_i),
    .pd_req_i(pd_req_i), .req_i(req_i), .rsp_o(rsp_o), .diagnostic_status_o(diagnostic_status_o),
    .error_latched_o(error_latched_o), .proc_freeze_o(proc_freeze_o),
    .startup_done_o(startup_done_o), .guard_enabled_o(guard_enabled_o),
    .int_rst_o(int_rst_o), .pd_ok_o(pd_ok_o));
`default_nettype wire

// ===== dv/gdsm_host.sv
// Host controller model issuing commands and collecting answers
`timescale 1ns/1ps
`default_nettype none
module gdsm_host #(
    parameter int unsigned WAIT_CYC = 1_500_000  // Settling wait before recovery, 30 ms
) (
    // Clock and answer
    input  wire logic                clock_i,
    input  wire gdsm_pkg::gdsm_rsp_t rsp_i,
    // Command
    output var gdsm_pkg::gdsm_req_t  req_o
);
    logic [7:0] last;
    logic       last_v;
    initial req_o = '0;
    // One command, raised after a falling edge; the answer is taken while its valid stands,
    // and an idle cycle follows so back-to-back calls never retouch the request at once
    task automatic xfer(input gdsm_pkg::gdsm_cmd_t c, input logic [1:0] s);
        req_o <= '{valid: 1'b1, cmd: c, step: s};
        @(negedge clock_i);
        last   = rsp_i.data;
        last_v = rsp_i.valid;
        req_o <= '0;
        @(negedge clock_i);
    endtask
    // Recovery: poll until recoverable flags clear, settle, open guard, recover, re-arm
    task automatic recover();
        do xfer(gdsm_pkg::GDSM_CMD_READ_STATUS, 2'h0);
        while (!(last[gdsm_pkg::BIT_ADC] && last[gdsm_pkg::BIT_EXC]));
        repeat (WAIT_CYC) @(negedge clock_i);
        for (int i = 1; i <= 3; i++) xfer(gdsm_pkg::GDSM_CMD_GUARD_DISABLE, 2'(i));
        xfer(gdsm_pkg::GDSM_CMD_RECOVER, 2'h0);
        xfer(gdsm_pkg::GDSM_CMD_GUARD_ENABLE, 2'h0);
    endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking testbench for the diagnostic status monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                clock_i  = 1'b0;
    logic                nrst_i   = 1'b0;
    gdsm_pkg::gdsm_mon_t mon_i    = '1;
    logic                pd_req_i = 1'b0;
    logic [11:0]         rate_i   = 12'h000;
    gdsm_pkg::gdsm_req_t req_i;
    gdsm_pkg::gdsm_rsp_t rsp_o;
    logic [7:0]          stat;
    logic                err, frz, sd, ge, irst, pdok;
    int                  errors = 0, compares = 0, cyc = 0, b, t0;

    initial forever #10 clock_i = ~clock_i;
    gdsm_host #(.WAIT_CYC(50)) host (.clock_i(clock_i), .rsp_i(rsp_o), .req_o(req_i));
    gdsm_top DUT (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1), .mon_i(mon_i),
        .pd_req_i(pd_req_i), .rate_i(rate_i), .req_i(req_i), .rsp_o(rsp_o),
        .diagnostic_status_o(stat), .error_latched_o(err), .proc_freeze_o(frz),
        .startup_done_o(sd), .guard_enabled_o(ge), .int_rst_o(irst), .pd_ok_o(pdok));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic results();
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] hi_of(input logic [11:0] r);
        return {{4{r[11]}}, r[11:8]};
    endfunction
    task automatic rd(input gdsm_pkg::gdsm_cmd_t c, input logic [7:0] exp);
        host.xfer(c, 2'h0);
        chk({7'h00, host.last_v}, 8'h01);
        chk(host.last, exp);
    endtask
    // Drop one raw flag, given by its status bit, for a single cycle
    task automatic pulse(input int sb);
        mon_i[sb-1] = 1'b0;
        @(negedge clock_i);
        mon_i = '1;
        repeat (2) @(negedge clock_i);
    endtask
    // Hang guard: whole run is about 84000 cycles
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errors++;
            $display("CHECK FAILED %0t run did not finish", $time);
            results();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(68));
        repeat (6) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk({7'h00, sd}, 8'h01);
        rd(gdsm_pkg::GDSM_CMD_READ_STATUS, 8'hff);
        for (int i = 0; i < 10; i++) begin
            rate_i = (i == 0) ? 12'h800 : (i == 1) ? 12'h7ff : 12'($urandom);
            rd(gdsm_pkg::GDSM_CMD_READ_RATE_HIGH, hi_of(rate_i));
            rd(gdsm_pkg::GDSM_CMD_READ_RATE_LOW, rate_i[7:0]);
        end
        pulse(4);
        chk({stat[4], err}, 8'h00);
        b = ($urandom & 1) ? 7 : 1;
        pulse(b);
        chk(stat, ~(8'h10 | (8'h01 << b)));
        chk({err, frz}, 8'h03);
        rd(gdsm_pkg::GDSM_CMD_READ_RATE_HIGH, 8'h80);
        rd(gdsm_pkg::GDSM_CMD_READ_RATE_LOW, 8'h80);
        // Guard only half opened: recovery must be ignored
        host.xfer(gdsm_pkg::GDSM_CMD_GUARD_DISABLE, 2'h1);
        host.xfer(gdsm_pkg::GDSM_CMD_GUARD_DISABLE, 2'h2);
        host.xfer(gdsm_pkg::GDSM_CMD_RECOVER, 2'h0);
        chk({7'h00, err}, 8'h01);
        // Half-open guard must be re-armed before a full recovery sequence
        host.xfer(gdsm_pkg::GDSM_CMD_GUARD_ENABLE, 2'h0);
        // Lasting error dropped well after the recoverable one: still stretched at recovery
        repeat (1000) @(negedge clock_i);
        t0 = cyc;
        pulse(6);
        // Stretch must last beyond 1.5 ms and end by 80010 cycles
        while (cyc < t0 + 75000) @(negedge clock_i);
        chk({7'h00, stat[6]}, 8'h00);
        host.recover();
        chk({7'h00, err}, 8'h01);
        while (cyc < t0 + 80010) @(negedge clock_i);
        chk({7'h00, stat[6]}, 8'h01);
        host.recover();
        chk({7'h00, err}, 8'h00);
        // Guard open: no new latch, but the supply still forces the error code
        for (int i = 1; i <= 3; i++) begin
            host.xfer(gdsm_pkg::GDSM_CMD_GUARD_DISABLE, 2'(i));
        end
        chk({7'h00, ge}, 8'h00);
        pulse(6);
        pulse(3);
        chk({7'h00, err}, 8'h00);
        rd(gdsm_pkg::GDSM_CMD_READ_RATE_HIGH, 8'h80);
        host.xfer(gdsm_pkg::GDSM_CMD_GUARD_ENABLE, 2'h0);
        chk({6'h00, err, ge}, 8'h03);
        pd_req_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk({6'h00, irst, pdok}, 8'h02);
        repeat (2400) @(negedge clock_i);
        chk({6'h00, irst, pdok}, 8'h02);
        repeat (200) @(negedge clock_i);
        chk({6'h00, irst, pdok}, 8'h03);
        // Second reset with excitation unlocked: start-up must not end
        pd_req_i = 1'b0;
        nrst_i   = 1'b0;
        mon_i[0] = 1'b0;
        repeat (2) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk({7'h00, sd}, 8'h00);
        rd(gdsm_pkg::GDSM_CMD_READ_RATE_HIGH, 8'h80);
        rd(gdsm_pkg::GDSM_CMD_READ_RATE_LOW, 8'h80);
        results();
    end
endmodule
`default_nettype wire
